// *** src/adc_seq_defines.svh ***
// constants of the serial conversion sequencer: edge positions, widths, reset values.
// assumes inclusion by bare name from the package and the sequencer top.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define CONV_EDGES 16
`define TRACK_EDGES 3
`define LEAD_ZEROS 4
`define RESULT_BITS 10
`define CTL_BITS 8
`define CHAN_MSB 5
`define CHAN_LSB 3
`define CHAN_DEFAULT 3'h0
`define FIFO_DEPTH 4
`endif

// *** src/adc_seq_pkg.sv ***
// types shared by the serial conversion sequencer and its bench.
// assumes the defines header sits beside it.
`include "adc_seq_defines.svh"
package adc_seq_pkg;
    typedef logic [3:0] edge_cnt_t;
    typedef logic [2:0] chan_t;
    typedef logic [`CTL_BITS-1:0] ctl_word_t;
    typedef logic [`RESULT_BITS-1:0] result_t;

    // rising-edge count c means the next falling edge is number c+1
    function automatic logic in_result_window(edge_cnt_t c);
        return (c >= edge_cnt_t'(`LEAD_ZEROS)) && (c < edge_cnt_t'(`LEAD_ZEROS + `RESULT_BITS));
    endfunction : in_result_window
endpackage : adc_seq_pkg

// *** src/sample_fifo.sv ***
// small synchronous fifo for conversion words.
// assumes one clock; depth a power of two, at least two.
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sample_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic in_ready_r;
    wire push = in_valid && in_ready_r;
    wire pop = out_valid && out_ready;

    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = in_ready_r;
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r <= count_nxt;
            // registered ready: full is known one cycle ahead from count_nxt
            in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
        count_r <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : sample_fifo
`default_nettype wire

// *** src/adc_serial_conversion_sequencer.sv ***
// digital sequencer and serial port of an eight-channel 10-bit sar converter.
// assumes words from the conversion datapath arrive on clk; the serial host
// drives sclk and cs_n; dout_oe decides the level of the shared data line.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_serial_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int RESULT_BITS = `RESULT_BITS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic [RESULT_BITS-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    output logic sample_switch,
    output logic comparator_balance_switch,
    output logic [2:0] channel_code,
    output logic powered_up,
    output logic result_underrun
);
    if (RESULT_BITS != `RESULT_BITS) begin : g_bad_width
        $error("shift pattern is fixed to a 10-bit result");
    end
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("fifo needs at least two words");
    end

    localparam edge_cnt_t LAST_CNT = edge_cnt_t'(`CONV_EDGES - 1);
    localparam edge_cnt_t TRACK_CNT = edge_cnt_t'(`TRACK_EDGES);
    localparam edge_cnt_t LOAD_CNT = edge_cnt_t'(`LEAD_ZEROS - 1);
    localparam edge_cnt_t CTL_CNT = edge_cnt_t'(`CTL_BITS);
    localparam edge_cnt_t CTL_LAST = edge_cnt_t'(`CTL_BITS - 1);

    // ---- system side: fifo and word handover ----
    logic [RESULT_BITS-1:0] fifo_data;
    logic fifo_valid;
    logic req_meta_r;
    logic req_sync_r;
    logic req_seen_r;
    logic [RESULT_BITS-1:0] word_r;
    logic underrun_r;
    // toggled on the serial side, read here through two flops
    logic link_req_r;
    wire req_edge = req_sync_r ^ req_seen_r;

    sample_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(result_data),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(req_edge)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            req_seen_r <= 1'b0;
        end else begin
            req_meta_r <= link_req_r;
            req_sync_r <= req_meta_r;
            req_seen_r <= req_sync_r;
        end
    end

    // word_r only moves right after a request toggle, so it is long settled
    // when the link samples it at the next hold start, 16 serial clocks on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= '0;
            underrun_r <= 1'b0;
        end else begin
            underrun_r <= req_edge && !fifo_valid;
            if (req_edge && fifo_valid) begin
                word_r <= fifo_data;
            end
        end
    end

    assign result_underrun = underrun_r;

    // ---- link side, on sclk; cs_n high holds the frame logic in reset ----
    edge_cnt_t rcnt_r;
    edge_cnt_t rcnt_nxt;
    ctl_word_t ctl_sh_r;
    ctl_word_t ctl_word_nxt;
    chan_t chan_pend_r;
    logic track_r;
    logic gap_r;
    logic dout_r;
    logic [RESULT_BITS-1:0] shift_r;
    wire data_bit = in_result_window(rcnt_r);
    wire load_word = (rcnt_r == LOAD_CNT);

    assign rcnt_nxt = (rcnt_r == LAST_CNT) ? '0 : rcnt_r + 4'h1;
    assign ctl_word_nxt = {ctl_sh_r[`CTL_BITS-2:0], din};

    // cs_n as asynchronous reset gates the serial clock off between frames
    // and drops any partial group, so the next frame restarts at zero
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rcnt_r <= '0;
            ctl_sh_r <= '0;
        end else begin
            rcnt_r <= rcnt_nxt;
            if (rcnt_r < CTL_CNT) begin
                ctl_sh_r <= ctl_word_nxt;
            end
        end
    end

    // channel survives between frames; it only resets with the chip
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            chan_pend_r <= `CHAN_DEFAULT;
        end else if (!cs_n && rcnt_r == CTL_LAST) begin
            chan_pend_r <= ctl_word_nxt[`CHAN_MSB:`CHAN_LSB];
        end
    end

    // falling edge k lies between rising edges k-1 and k whether the frame
    // opened with sclk high or low, so edge number is rcnt_r+1 here; with
    // sclk low at select fall, the reset values already are edge one's
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            track_r <= 1'b1;
            gap_r <= 1'b0;
            dout_r <= 1'b0;
            shift_r <= '0;
        end else begin
            track_r <= (rcnt_r < TRACK_CNT);
            gap_r <= (rcnt_r == LAST_CNT);
            dout_r <= data_bit ? shift_r[RESULT_BITS-1] : 1'b0;
            if (load_word) begin
                shift_r <= word_r;
            end else if (data_bit) begin
                shift_r <= {shift_r[RESULT_BITS-2:0], 1'b0};
            end
        end
    end

    // toggle per conversion asks the system side for the next word
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            link_req_r <= 1'b0;
        end else if (!cs_n && load_word) begin
            link_req_r <= ~link_req_r;
        end
    end

    // dout_oe and powered_up must react to cs_n with no sclk edge, so they
    // are gated by the pin itself rather than taken from a flop
    assign dout = dout_r;
    assign dout_oe = ~cs_n;
    assign powered_up = ~cs_n & ~gap_r;
    assign sample_switch = track_r;
    assign comparator_balance_switch = track_r;
    assign channel_code = chan_pend_r;

    // ---- checks ----
    a_hold_starts: assert property (@(negedge sclk) disable iff (cs_n)
        $fell(track_r) |-> (rcnt_r == 4'h4))
        else $error("hold did not begin on fourth falling edge");

    a_track_resumes: assert property (@(negedge sclk) disable iff (cs_n)
        $rose(track_r) |-> (rcnt_r == 4'h1) || (rcnt_r == 4'h0))
        else $error("track did not resume after sixteenth rising edge");

    a_track_span: assert property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r == 4'h0) |=> track_r ##1 track_r ##1 track_r ##1 !track_r)
        else $error("track phase is not three cycles");

    a_pad_zeros: assert property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r < 4'h4 || rcnt_r > 4'hd) |=> !dout_r)
        else $error("padding bit is not zero");

    a_msb_first: assert property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r == 4'h3) |-> ##2 (dout_r == $past(word_r[RESULT_BITS-1], 2)))
        else $error("first result bit is not the msb of the word");

    a_lsb_last: assert property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r == 4'h3) |-> ##11 (dout_r == $past(word_r[0], 11)))
        else $error("tenth result bit is not the lsb of the word");

    a_ctl_capture: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
        (rcnt_r == 4'h7) |=> (chan_pend_r == $past(ctl_word_nxt[5:3])))
        else $error("channel not taken from eighth control bit");

    a_chan_stable: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
        (rcnt_r != 4'h7) |=> $stable(chan_pend_r))
        else $error("channel changed outside the control window");

    a_group_wrap: assert property (@(posedge sclk) disable iff (cs_n)
        (rcnt_r == 4'hf) |=> (rcnt_r == 4'h0))
        else $error("group counter did not wrap after sixteen edges");

    a_power_gap: assert property (@(negedge sclk) disable iff (cs_n)
        $rose(gap_r) |-> (rcnt_r == 4'h0) && (track_r == 1'b0))
        else $error("power gap not after sixteenth falling edge");

    a_req_pops: assert property (@(posedge clk) disable iff (!rst_n)
        (req_edge && fifo_valid) |=> (word_r == $past(fifo_data)))
        else $error("requested word not taken from fifo");

    c_back_to_back: cover property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r == 4'hf) ##1 (rcnt_r == 4'h0) ##1 track_r);

    c_channel_seven: cover property (@(posedge sclk) disable iff (!rst_n || cs_n)
        (rcnt_r == 4'h7) ##1 (chan_pend_r == 3'h7));

    c_underrun: cover property (@(posedge clk) disable iff (!rst_n)
        underrun_r);

    c_word_shifted: cover property (@(negedge sclk) disable iff (cs_n)
        (rcnt_r == 4'h3) ##1 (rcnt_r == 4'h4) ##1 dout_r);
endmodule : adc_serial_conversion_sequencer
`default_nettype wire

// *** verif/serial_host_model.sv ***
// serial host model: frames of 16-edge groups, cut short mid-group if asked, records what it sees.
// assumes the bench resolves the shared data line from dout and dout_oe.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dline,
    input wire logic track,
    input wire logic pwr,
    input wire logic [2:0] chan
);
    logic [15:0] rx [4];
    logic [15:0] trk [4];
    logic [15:0] pw [4];
    logic [2:0] cc [4];
    logic [7:0] ctl [4];
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // mode 0: clock high at select fall, 1: clock low first, 2: both together
    // stop > 0 raises select after that many rises, mid-group
    task automatic frame(input int groups, input int mode, input int stop);
        int g;
        int j;
        for (int k = 0; k < groups * 16; k++) begin
            g = k / 16;
            j = k % 16;
            din = (j < 8) ? ctl[g][7 - j] : ~din;
            if (k > 0) begin
                sclk = 1'b0;
            end else if (mode == 0) begin
                cs_n = 1'b0;
                #3 sclk = 1'b0;
            end else if (mode == 1) begin
                sclk = 1'b0;
                #3 cs_n = 1'b0;
            end else begin
                cs_n = 1'b0;
                sclk = 1'b0;
            end
            #1 trk[g][15 - j] = track;
            pw[g][15 - j] = pwr;
            #2 rx[g][15 - j] = dline;
            sclk = 1'b1;
            #3 if (j == 15) cc[g] = chan;
            if (k + 1 == stop) break;
        end
        cs_n = 1'b1;
        #3;
    endtask : frame
    // clock runs with select high; the device must not react
    task automatic wiggle(input int n);
        repeat (n) begin
            #3 sclk = 1'b0;
            din = ~din;
            #3 sclk = 1'b1;
        end
    endtask : wiggle
endmodule : serial_host_model
`default_nettype wire

// *** verif/adc_serial_conversion_sequencer_tb.sv ***
// bench of the serial conversion sequencer: fifo pushes on clk, host frames on sclk.
// assumes the serial host model drives the link with a 6 ns clock.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_conversion_sequencer_tb;
    import adc_seq_pkg::*;
    logic clk;
    logic rst_n;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    result_t result_data;
    logic result_valid;
    logic result_ready;
    logic sample_switch;
    logic comparator_balance_switch;
    chan_t channel_code;
    logic powered_up;
    logic result_underrun;
    wire logic dline;
    int mismatches = 0;
    int tests_run = 0;
    int underruns = 0;
    result_t w [5] = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001, 10'h200};
    result_t ex [4];
    chan_t cd [4];
    // released line shows the inverse of dout, which cs_n high clears to zero
    assign dline = dout_oe ? dout : ~dout;
    adc_serial_conversion_sequencer i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .sample_switch(sample_switch),
        .comparator_balance_switch(comparator_balance_switch), .channel_code(channel_code),
        .powered_up(powered_up), .result_underrun(result_underrun));
    serial_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dline(dline), .track(sample_switch),
        .pwr(powered_up), .chan(channel_code));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (result_underrun === 1'b1) underruns++;
    end
    task automatic test_done();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic push(input result_t d);
        int n;
        n = 0;
        @(posedge clk);
        result_data <= d;
        result_valid <= 1'b1;
        @(negedge clk);
        while (result_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        result_valid <= 1'b0;
        if (n == 20) begin
            mismatches++;
            test_done();
        end
    endtask : push
    task automatic run(input int groups, input int mode, input bit data);
        for (int g = 0; g < groups; g++) i_host.ctl[g] = {2'b11, cd[g], 3'b101};
        i_host.frame(groups, mode, 0);
        for (int g = 0; g < groups; g++) begin
            if (data) chk(i_host.rx[g], {4'h0, ex[g], 2'h0});
            chk(i_host.trk[g], 16'he000);
            chk(i_host.pw[g], 16'hfffe);
            chk(16'(i_host.cc[g]), 16'(cd[g]));
        end
        chk(16'(dout_oe), 16'h0);
    endtask : run
    initial begin
        rst_n = 1'b0;
        result_valid = 1'b0;
        result_data = '0;
        repeat (16) @(posedge clk);
        chk(16'(channel_code), 16'h0);
        chk(16'(dout_oe), 16'h0);
        chk(16'(powered_up), 16'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) push(w[i]);
        repeat (2) @(negedge clk);
        chk(16'(result_ready), 16'h0);
        ex = '{10'h000, w[0], w[1], w[2]};
        cd = '{3'h1, 3'h2, 3'h3, 3'h4};
        run(4, 0, 1'b1);
        repeat (8) @(negedge clk);
        chk(16'(result_ready), 16'h1);
        push(w[4]);
        ex[0] = w[3];
        ex[1] = w[4];
        cd[0] = 3'h5;
        cd[1] = 3'h6;
        run(2, 1, 1'b1);
        repeat (8) @(negedge clk);
        chk(16'(underruns), 16'h1);
        i_host.ctl[0] = {2'b11, 3'h3, 3'b101};
        i_host.frame(1, 0, 5);
        chk(16'(channel_code), 16'h6);
        chk(16'(dout_oe), 16'h0);
        i_host.wiggle(20);
        chk(16'(channel_code), 16'h6);
        chk(16'(powered_up), 16'h0);
        chk(16'(comparator_balance_switch), 16'h1);
        cd[0] = 3'h7;
        cd[1] = 3'h0;
        // word after an underrun is the held word_r sent again, so data is not compared here
        run(2, 2, 1'b0);
        test_done();
    end
endmodule : adc_serial_conversion_sequencer_tb
`default_nettype wire
